// ==== design/rsc_pkg.sv ====
// package: register map, field positions and timing counts of the reset source controller
package rsc_pkg;
  // ----------------------------------------
  // register indices (printed offsets) and byte addresses
  // ----------------------------------------
  localparam logic [7:0] RSC_IDX_CAUSE = 8'hef;
  localparam logic [7:0] RSC_IDX_SUPPLY = 8'hff;
  localparam logic [11:0] RSC_ADDR_CAUSE = {2'h0, RSC_IDX_CAUSE, 2'h0};
  localparam logic [11:0] RSC_ADDR_SUPPLY = {2'h0, RSC_IDX_SUPPLY, 2'h0};
  // ----------------------------------------
  // reset-cause register fields
  // ----------------------------------------
  localparam int RSC_B_PIN = 0;
  localparam int RSC_B_POR = 1;
  localparam int RSC_B_CLK = 2;
  localparam int RSC_B_WDG = 3;
  localparam int RSC_B_SW = 4;
  localparam int RSC_B_CMP = 5;
  localparam int RSC_B_FLASH = 6;
  // ----------------------------------------
  // supply-monitor control fields
  // ----------------------------------------
  localparam int RSC_B_MON_EN = 7;
  localparam int RSC_B_MON_STAT = 6;
  // ----------------------------------------
  // reset values and constants
  // ----------------------------------------
  localparam logic [7:0] RSC_PORT_RESET = 8'hff;
  localparam logic [15:0] RSC_PC_RESET = 16'h0000;
  localparam logic [15:0] RSC_USER_LIMIT = 16'h7dff;
  localparam logic [3:0] RSC_WDG_DIV = 4'hc;
  localparam int RSC_CLK_MHZ = 100;
  localparam int RSC_CLK_LOSS_US = 100;
  localparam int RSC_CLK_LOSS_CYC = RSC_CLK_LOSS_US * RSC_CLK_MHZ;
  localparam int RSC_HOLD_CYC = 4;
endpackage : rsc_pkg

// ==== design/rsc_controller.sv ====
// reset source controller: request gathering, reset hold, cause flags and APB registers
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

// Overview of operation
// [RULE1] in reset: core halted, registers reset, ports forced, interrupts and timers off
// [RULE2] data memory untouched by reset; only stack pointer reinitialised
// [RULE3] port latches all ones open-drain in reset; weak pull-ups on always
// [RULE4] power-on and supply resets drive reset pin low until reset exit
// [RULE5] on reset exit program counter cleared and internal oscillator selected
// [RULE6] after any reset watchdog enabled, clocked by system clock over twelve
// [RULE7] power-on sets power-on flag bit 1; other resets clear it
// [RULE8] power-on enables and selects supply monitor; other resets keep its state
// [RULE9] enabled selected monitor below threshold holds reset and pin low
// [RULE10] software enables monitor, waits, then selects it as source
// [RULE11] supply control bit 7 switches monitor; no reset unless selected
// [RULE12] supply bit 6 reads live monitor output; bits 4..0 read variable; the code reads bits 5..0 as zero
// [RULE13] external low on reset pin resets; pin flag bit 0 set
// [RULE14] clock-loss detector resets after timeout; bit 2 flag and enable
// [RULE15] writing bit 5 enables comparator reset; flag reads 1 after it
// [RULE16] software lets comparator settle before enabling it as a source
// [RULE17] watchdog timeout resets and sets watchdog flag bit 3
// [RULE18] flash access above user limit or blocked resets, flag bit 6
// [RULE19] writing 1 to bit 4 forces reset, flag reads 1; 0 ignored
// [RULE20] power-on bit write selects monitor; reads 1 after power or supply reset
// [RULE21] non-supply resets never drive the reset pin
// [RULE22] asynchronous requests synchronised; causes captured with reset assertion
// [RULE23] cause flags held through reset; change only on new reset or writes
module rsc_controller (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_power_on,
  input wire logic i_supply_above,
  input wire logic i_reset_pin_n,
  input wire logic i_clock_stuck,
  input wire logic i_comparator_low,
  input wire logic i_watchdog_timeout,
  input wire logic i_program_store_write_enable,
  input wire logic i_flash_write,
  input wire logic i_code_space_read,
  input wire logic i_branch,
  input wire logic [15:0] i_flash_addr,
  input wire logic i_flash_blocked,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe,
  output logic o_system_reset,
  output logic o_core_halt,
  output logic o_sfr_reset,
  output logic o_interrupt_disable,
  output logic o_sp_reset,
  output logic [7:0] o_port_latch,
  output logic o_port_open_drain,
  output logic o_weak_pullup,
  output logic [15:0] o_pc_load,
  output logic o_pc_load_en,
  output logic o_osc_internal_sel,
  output logic o_watchdog_enable,
  output logic [3:0] o_watchdog_div,
  output logic o_supply_monitor_enable
);
  import rsc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  function automatic logic settle(input logic a, input logic b, input logic old);
    settle = (a == b) ? a : old;
  endfunction : settle

  logic [6:0] s1_r, s2_r, s3_r, live_r;
  logic [6:0] raw;
  assign raw = {i_power_on, i_supply_above, ~i_reset_pin_n, i_clock_stuck,
                i_comparator_low, i_watchdog_timeout, i_flash_blocked};

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge i_clock) begin
    s1_r <= raw;
    s2_r <= s1_r;
    s3_r <= s2_r;
    for (int k = 0; k < 7; k++) begin
      if (i_sys_rst) begin
        live_r[k] <= (k == 5) ? 1'b1 : 1'b0;
      end else begin
        live_r[k] <= settle(s2_r[k], s3_r[k], live_r[k]); // RULE22
      end
    end
  end

  logic por_q, sup_above_q, pin_q, stuck_q, cmp_q, wdg_q, blk_q;
  assign {por_q, sup_above_q, pin_q, stuck_q, cmp_q, wdg_q, blk_q} = live_r;

  // ----------------------------------------
  // control bits and requests
  // ----------------------------------------
  logic mon_en_r, mon_sel_r, clk_en_r, cmp_en_r, sw_req_r;
  logic [6:0] cause_r;
  logic in_reset_r, pin_drive_r;
  logic [2:0] hold_r;
  logic wr_cause, wr_supply, acc;

  // one address compare shared by the strobes, the error and the read mux
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  assign acc = i_psel & i_penable;
  assign wr_cause = acc & i_pwrite & i_pstrb[0] & addr_is(i_paddr, RSC_ADDR_CAUSE);
  assign wr_supply = acc & i_pwrite & i_pstrb[0] & addr_is(i_paddr, RSC_ADDR_SUPPLY);

  // flash address check above user space
  logic flash_err;
  assign flash_err = blk_q |
    (((i_flash_write & i_program_store_write_enable) | i_code_space_read | i_branch)
     & (i_flash_addr > RSC_USER_LIMIT)); // RULE18

  // ----------------------------------------
  // pin echo mask
  // ----------------------------------------
  // the synchronised pin trails our own drive by up to four edges; without
  // this mask the tail of a supply reset would be logged as a pin reset
  logic [3:0] drive_hist_r;
  logic pin_masked;
  assign pin_masked = pin_drive_r | (|drive_hist_r);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      drive_hist_r <= 4'hf;
    end else begin
      drive_hist_r <= {drive_hist_r[2:0], pin_drive_r}; // RULE13
    end
  end

  logic sup_req, pin_req, clk_req, cmp_req, any_req;
  assign sup_req = por_q | (mon_en_r & mon_sel_r & ~sup_above_q); // RULE9 RULE11
  assign pin_req = pin_q & ~pin_masked; // RULE13
  assign clk_req = clk_en_r & stuck_q; // RULE14
  assign cmp_req = cmp_en_r & cmp_q; // RULE15
  assign any_req = sup_req | pin_req | clk_req | cmp_req | wdg_q | flash_err | sw_req_r;

  // ----------------------------------------
  // reset hold sequence
  // ----------------------------------------
  // a short hold after the last request keeps release glitch-free
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      in_reset_r <= 1'b1;
      hold_r <= 3'(RSC_HOLD_CYC);
      pin_drive_r <= 1'b1;
    end else if (any_req) begin
      in_reset_r <= 1'b1; // RULE22
      hold_r <= 3'(RSC_HOLD_CYC);
      pin_drive_r <= sup_req; // RULE4 RULE21
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end else begin
      in_reset_r <= 1'b0;
      pin_drive_r <= 1'b0; // RULE4
    end
  end

  // ----------------------------------------
  // cause flags, recorded at assertion and held
  // ----------------------------------------
  logic entering;
  assign entering = any_req & ~in_reset_r;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cause_r <= 7'h02;
    end else if (any_req) begin
      // only the first request cycle overwrites; later ones accumulate
      if (entering) begin
        cause_r <= 7'h00;
      end
      if (sup_req) cause_r[RSC_B_POR] <= 1'b1; // RULE7 RULE20
      if (pin_req) cause_r[RSC_B_PIN] <= 1'b1; // RULE13
      if (clk_req) cause_r[RSC_B_CLK] <= 1'b1; // RULE14
      if (cmp_req) cause_r[RSC_B_CMP] <= 1'b1; // RULE15
      if (wdg_q) cause_r[RSC_B_WDG] <= 1'b1; // RULE17
      if (flash_err) cause_r[RSC_B_FLASH] <= 1'b1; // RULE18
      if (sw_req_r) cause_r[RSC_B_SW] <= 1'b1; // RULE19
    end
  end

  // ----------------------------------------
  // software-written enables
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mon_en_r <= 1'b1;
      mon_sel_r <= 1'b1;
      clk_en_r <= 1'b0;
      cmp_en_r <= 1'b0;
      sw_req_r <= 1'b0;
    end else begin
      sw_req_r <= wr_cause & i_pwdata[RSC_B_SW]; // RULE19
      if (por_q) begin
        mon_en_r <= 1'b1; // RULE8
        mon_sel_r <= 1'b1;
      end else begin
        if (wr_supply) mon_en_r <= i_pwdata[RSC_B_MON_EN]; // RULE11
        if (wr_cause) mon_sel_r <= i_pwdata[RSC_B_POR]; // RULE20 RULE10
      end
      if (wr_cause) begin
        clk_en_r <= i_pwdata[RSC_B_CLK]; // RULE14
        cmp_en_r <= i_pwdata[RSC_B_CMP]; // RULE15 RULE16
      end
    end
  end

  // ----------------------------------------
  // apb slave: zero wait, unmapped reads zero with error
  // ----------------------------------------
  logic mapped;
  assign mapped = addr_is(i_paddr, RSC_ADDR_CAUSE) | addr_is(i_paddr, RSC_ADDR_SUPPLY);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      if (addr_is(i_paddr, RSC_ADDR_CAUSE)) begin
        o_prdata <= {25'h0, cause_r}; // RULE23
      end else if (addr_is(i_paddr, RSC_ADDR_SUPPLY)) begin
        o_prdata <= {24'h0, mon_en_r, sup_above_q, 6'h00}; // RULE12
      end else begin
        o_prdata <= 32'h0;
      end
    end
  end

  // ----------------------------------------
  // system-facing outputs
  // ----------------------------------------
  logic exit_r;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) exit_r <= 1'b1;
    else exit_r <= in_reset_r;
  end

  assign o_system_reset = in_reset_r;
  assign o_core_halt = in_reset_r; // RULE1
  assign o_sfr_reset = in_reset_r; // RULE1
  assign o_interrupt_disable = in_reset_r; // RULE1
  assign o_sp_reset = in_reset_r; // RULE2
  assign o_port_latch = RSC_PORT_RESET; // RULE3
  assign o_port_open_drain = in_reset_r; // RULE3
  assign o_weak_pullup = 1'b1; // RULE3
  assign o_reset_pin_out = 1'b0;
  assign o_reset_pin_oe = pin_drive_r; // RULE4 RULE21
  assign o_pc_load = RSC_PC_RESET; // RULE5
  assign o_pc_load_en = exit_r & ~in_reset_r; // RULE5
  assign o_osc_internal_sel = exit_r & ~in_reset_r; // RULE5
  assign o_watchdog_enable = exit_r & ~in_reset_r; // RULE6
  assign o_watchdog_div = RSC_WDG_DIV; // RULE6
  assign o_supply_monitor_enable = mon_en_r; // RULE8

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence sw_write_s;
    wr_cause && i_pwdata[RSC_B_SW];
  endsequence

  sw_reset_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE19
    sw_write_s |=> ##1 in_reset_r && cause_r[RSC_B_SW])
    else $error("software reset not taken");

  pin_drive_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE21
    (any_req && !sup_req && !in_reset_r) |=> !o_reset_pin_oe)
    else $error("reset pin driven by non-supply reset");

  supply_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE9
    sup_req |=> in_reset_r && o_reset_pin_oe)
    else $error("supply reset not held");

  por_flag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE7
    por_q |=> cause_r[RSC_B_POR])
    else $error("power-on flag not set");

  por_enable_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE8
    por_q |=> mon_en_r && mon_sel_r)
    else $error("power-on did not enable monitor");

  flash_err_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE18
    (i_code_space_read && i_flash_addr > RSC_USER_LIMIT) |=> cause_r[RSC_B_FLASH])
    else $error("flash error flag missing");

  cause_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE23
    !any_req |=> $stable(cause_r))
    else $error("cause flags changed without reset");

  exit_pc_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE5
    $fell(in_reset_r) |-> o_pc_load_en && o_watchdog_enable ##1 !o_pc_load_en)
    else $error("reset exit pulse wrong");

  release_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE22
    $fell(in_reset_r) |-> $past(!any_req, 1) && $past(hold_r, 1) == 3'h0)
    else $error("early reset release");

  // ----------------------------------------
  // assertions: hold timing and flag bookkeeping
  // ----------------------------------------
  // a request keeps reset up for the whole hold, and a quiet hold ends it
  sequence held_s;
    in_reset_r [*5];
  endsequence

  sequence idle_hold_s;
    in_reset_r && !any_req;
  endsequence

  hold_min_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE22
    any_req |=> held_s)
    else $error("reset shorter than the hold");

  hold_end_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE22
    idle_hold_s [*5] |=> !in_reset_r)
    else $error("reset held past the hold");

  // any entry not from the supply path wipes the power-on flag
  clear_por_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE7
    (entering && !sup_req) |=> !cause_r[RSC_B_POR])
    else $error("power-on flag kept by other reset");

  // monitor enable moves only by power-on or a supply register write
  mon_keep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE8
    (!por_q && !wr_supply) |=> $stable(mon_en_r))
    else $error("monitor enable changed by other reset");

  // our own drive must not come back as a pin reset once released
  sequence pin_settle_s;
    !pin_req [*4];
  endsequence

  pin_echo_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE13
    $fell(o_reset_pin_oe) |=> pin_settle_s)
    else $error("own pin drive seen as pin reset");

  // each accepted pin, clock-loss, comparator or watchdog request enters reset and leaves its own flag
  pin_flag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE13
    pin_req |=> in_reset_r && cause_r[RSC_B_PIN])
    else $error("pin reset flag missing");

  clk_flag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE14
    clk_req |=> in_reset_r && cause_r[RSC_B_CLK])
    else $error("clock loss flag missing");

  cmp_flag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE15
    cmp_req |=> in_reset_r && cause_r[RSC_B_CMP])
    else $error("comparator flag missing");

  wdg_flag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE17
    wdg_q |=> in_reset_r && cause_r[RSC_B_WDG])
    else $error("watchdog flag missing");

  // a zero in the software bit must not start a reset
  sw_zero_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE19
    (wr_cause && !i_pwdata[RSC_B_SW]) |=> !sw_req_r)
    else $error("software reset from a zero write");

  // status bit carries the monitor level seen at the read setup
  status_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE12
    (i_psel && !i_penable && !i_pwrite && addr_is(i_paddr, RSC_ADDR_SUPPLY))
    |=> o_prdata[RSC_B_MON_STAT] == $past(sup_above_q))
    else $error("supply status read wrong");

  // the pin is let go on the same edge as the reset
  pin_release_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE4
    $fell(in_reset_r) |-> !o_reset_pin_oe)
    else $error("reset pin held after exit");
endmodule : rsc_controller

// ==== test/rsc_far_side.sv ====
// far-side model: reset pin with pull-up and supply monitor output
`timescale 1ns/1ps
module rsc_far_side (
  input wire logic i_ext_pin_low,
  input wire logic i_supply_low,
  input wire logic i_pin_oe,
  input wire logic i_pin_out,
  output logic o_pin_n,
  output logic o_supply_above
);
  // ----------------------------------------
  // pin level
  // ----------------------------------------
  // device drive wins, then external pull-down, else the pull-up
  assign o_pin_n = i_pin_oe ? i_pin_out : !i_ext_pin_low;
  // monitor output tracks the modelled supply level
  assign o_supply_above = !i_supply_low;
endmodule : rsc_far_side

// ==== test/testbench.sv ====
// testbench: drives reset requests and register accesses, judges the controller
`timescale 1ns/1ps
module testbench;
  import rsc_pkg::*;
  logic clk = 0, rst = 1, pin_low = 0, sup_low = 0, stuck = 0, cmp = 0, wdg = 0, pwr = 0;
  logic sel = 0, en = 0, wr = 0, program_store_write_enable = 1, perr;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0, rdata, prdata;
  logic [3:0] fl = '0;
  logic [15:0] faddr = '0, pc;
  logic pin_n, sup_above, pready, pslverr, oe, pin_out, sys_reset, pc_en, osc, wden;
  logic halt, sfr, intd, sp, od, pull, mon_en;
  logic [7:0] latch;
  logic [3:0] wdiv;
  int n_errors = 0, n_compared = 0;
  // free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  rsc_far_side far (.i_ext_pin_low(pin_low), .i_supply_low(sup_low), .i_pin_oe(oe),
    .i_pin_out(pin_out), .o_pin_n(pin_n), .o_supply_above(sup_above));
  rsc_controller DUT (.i_clock(clk), .i_sys_rst(rst), .i_power_on(pwr),
    .i_supply_above(sup_above), .i_reset_pin_n(pin_n), .i_clock_stuck(stuck),
    .i_comparator_low(cmp), .i_watchdog_timeout(wdg), .i_program_store_write_enable(program_store_write_enable),
    .i_flash_write(fl[0]), .i_code_space_read(fl[1]), .i_branch(fl[2]),
    .i_flash_addr(faddr), .i_flash_blocked(fl[3]), .i_psel(sel), .i_penable(en),
    .i_pwrite(wr), .i_paddr(addr), .i_pwdata(wdata), .i_pstrb(4'hf), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_reset_pin_out(pin_out), .o_reset_pin_oe(oe),
    .o_system_reset(sys_reset), .o_core_halt(halt), .o_sfr_reset(sfr),
    .o_interrupt_disable(intd), .o_sp_reset(sp), .o_port_latch(latch),
    .o_port_open_drain(od), .o_weak_pullup(pull), .o_pc_load(pc), .o_pc_load_en(pc_en),
    .o_osc_internal_sel(osc), .o_watchdog_enable(wden), .o_watchdog_div(wdiv),
    .o_supply_monitor_enable(mon_en));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    sel <= 1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    en <= 1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rdata = prdata;
    perr = pslverr;
    sel <= 0;
    en <= 0;
    if (i >= 20) begin
      n_errors++;
      give_verdict();
    end
  endtask : apb
  // bounded wait for the system reset level
  task automatic wait_rst(input logic v);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (sys_reset === v) break;
    end
    if (i >= 60) begin
      n_errors++;
      give_verdict();
    end
  endtask : wait_rst
  task automatic quiet();
    logic s;
    s = 0;
    repeat (12) begin
      @(posedge clk);
      s |= sys_reset;
    end
    check(s, 0);
  endtask : quiet
  // whole reset: state in reset, pin drive, exit pulses, recorded cause
  task automatic reset_seq(input logic [7:0] cause, input logic drive);
    logic s;
    wait_rst(1);
    check(oe, drive);
    check(pin_out, 0);
    check({halt, sfr, intd, sp, od, pull, latch}, {6'h3f, RSC_PORT_RESET});
    {pin_low, sup_low, stuck, cmp, wdg, pwr, fl} <= '0;
    wait_rst(0);
    s = pc_en & osc & wden;
    check({halt, sfr, intd, sp, od}, 5'h00);
    repeat (2) begin
      @(posedge clk);
      s |= pc_en & osc & wden;
    end
    check(s, 1);
    check({pc, wdiv, pull}, {RSC_PC_RESET, RSC_WDG_DIV, 1'b1});
    apb(0, RSC_ADDR_CAUSE, '0);
    check(rdata, {24'h0, cause});
  endtask : reset_seq
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_power();
    wait_rst(0);
    apb(0, RSC_ADDR_CAUSE, '0);
    check(rdata, 32'h02);
    apb(0, RSC_ADDR_SUPPLY, '0);
    check(rdata, 32'hc0);
    apb(0, 12'h010, '0);
    check(perr, 1);
    check(rdata, 32'h0);
  endtask : s_power
  task automatic s_soft();
    apb(1, RSC_ADDR_CAUSE, 32'h02);
    quiet();
    apb(1, RSC_ADDR_CAUSE, 32'h12);
    reset_seq(8'h10, 0);
  endtask : s_soft
  task automatic s_pin();
    pin_low <= 1;
    reset_seq(8'h01, 0);
  endtask : s_pin
  task automatic s_supply();
    sup_low <= 1;
    wait_rst(1);
    repeat (8) @(posedge clk);
    check({sys_reset, oe}, 2'b11);
    reset_seq(8'h02, 1);
  endtask : s_supply
  task automatic s_sources();
    apb(1, RSC_ADDR_CAUSE, 32'h26);
    cmp <= 1;
    reset_seq(8'h20, 0);
    apb(1, RSC_ADDR_CAUSE, 32'h26);
    stuck <= 1;
    reset_seq(8'h04, 0);
    wdg <= 1;
    reset_seq(8'h08, 0);
  endtask : s_sources
  task automatic s_flash();
    fl <= 4'h2;
    faddr <= RSC_USER_LIMIT;
    quiet();
    fl <= 4'h1;
    faddr <= 16'h7e00;
    program_store_write_enable <= 0;
    quiet();
    program_store_write_enable <= 1;
    for (int k = 0; k < 4; k++) begin
      fl <= 4'h1 << k;
      faddr <= (k == 3) ? 16'h0000 : 16'h7e00;
      reset_seq(8'h40, 0);
    end
  endtask : s_flash
  task automatic s_monitor();
    apb(1, RSC_ADDR_SUPPLY, 32'h00);
    sup_low <= 1;
    quiet();
    apb(0, RSC_ADDR_SUPPLY, '0);
    check(mon_en, 0);
    check(rdata, 32'h0);
    sup_low <= 0;
    apb(1, RSC_ADDR_CAUSE, 32'h12);
    reset_seq(8'h10, 0);
    apb(0, RSC_ADDR_SUPPLY, '0);
    check(rdata, 32'h40);
    pwr <= 1;
    reset_seq(8'h02, 1);
    apb(0, RSC_ADDR_SUPPLY, '0);
    check(rdata, 32'hc0);
  endtask : s_monitor
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    check(oe, 1);
    rst <= 0;
    s_power();
    s_soft();
    s_pin();
    s_supply();
    s_sources();
    s_flash();
    s_monitor();
    give_verdict();
  end
endmodule : testbench
